// ===== hdl/aoa_cfg.svh
// Register map, field positions, reset values and timing counts of the alarm output block
// Functional notes
// - Averaging, on>=off: actuate at mean>=on, release at mean<=off.
// - Averaging, on<off: actuate when mean falls to or below on.
// - Mean thresholds count only in averaging mode, ignored in voting mode.
// - Fault option set: any assigned input lost fault actuates the output.
// - Actuation waits for the make delay, 0..9999 s, default 10 s.
// - Release waits for the break delay, up to 9999 s, default 10 s; a latched output released by a latch clear goes off at once.
// - A disabled output stays inactive and ignores its inputs.
// - Latched output stays actuated until a latch clear request.
// - Sounder outputs share modes, thresholds, fault option and delays with relays.
// - Only inputs assigned to the output affect it.
// - Voting: actuate when assigned inputs in alarm reach the voting count.
// - Coil sense selectable: normally de-energized or normally energized.
`ifndef AOA_CFG_SVH
`define AOA_CFG_SVH
`define AOA_CTRL_OFS 8'h00
`define AOA_ASSIGN_OFS 8'h04
`define AOA_AVG_ON_OFS 8'h08
`define AOA_AVG_OFF_OFS 8'h0c
`define AOA_MAKE_OFS 8'h10
`define AOA_BRK_OFS 8'h14
`define AOA_STAT_OFS 8'h18
`define AOA_ISTAT_OFS 8'h1c
`define AOA_IMASK_OFS 8'h20
`define AOA_CMD_OFS 8'h24
`define AOA_CTRL_EN 0
`define AOA_CTRL_MODE 1
`define AOA_CTRL_FAULT 2
`define AOA_CTRL_LATCH 3
`define AOA_CTRL_SENSE 4
`define AOA_CTRL_STYLE 5
`define AOA_CTRL_VOTE_LSB 8
`define AOA_CTRL_RST 32'h0000_0100
`define AOA_ASSIGN_RST 32'h0000_0000
`define AOA_AVG_RST 16'h0000
`define AOA_DLY_DEF 14'h000a
`define AOA_DLY_MAX 14'h270f
`define AOA_IRQ_ACT 0
`define AOA_IRQ_REL 1
`define AOA_IRQ_FLT 2
`define AOA_CLK_HZ 40000000
`define AOA_TICK_S 1
`define AOA_TICK_CYCLES (`AOA_CLK_HZ * `AOA_TICK_S)
`endif

// ===== hdl/aoa_pkg.sv
// Types shared by the alarm output block
package aoa_pkg;
  typedef enum logic {AOA_MODE_VOTE = 1'b0, AOA_MODE_AVG = 1'b1} aoa_mode_e;
  typedef enum logic [1:0] {
    AOA_ST_OFF = 2'b00,
    AOA_ST_MAKE = 2'b01,
    AOA_ST_ON = 2'b10,
    AOA_ST_BRK = 2'b11
  } aoa_state_e;
  typedef logic [13:0] aoa_dly_t;
endpackage : aoa_pkg

// ===== hdl/aoa_dec_if.sv
// Decision signals passed between evaluator, delay stage and top
`timescale 1ns/100ps
interface aoa_dec_if;
  logic en;
  logic req;
  logic any_fault;
  logic latched;
  logic clr;
  aoa_pkg::aoa_dly_t make_dly;
  aoa_pkg::aoa_dly_t brk_dly;
  logic act;
  modport eval (input en, output req, output any_fault);
  modport dly (input en, input req, input latched, input clr, input make_dly,
    input brk_dly, output act);
endinterface : aoa_dec_if

// ===== hdl/aoa_eval.sv
// Alarm condition evaluator: voting, averaging hysteresis and fault option
`timescale 1ns/100ps
`include "aoa_cfg.svh"
module aoa_eval #(
  parameter int NUM_IN = 8,
  parameter int CONC_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_IN*CONC_W-1:0] conc,
  input wire logic [NUM_IN-1:0] alarm,
  input wire logic [NUM_IN-1:0] fault,
  input wire logic [NUM_IN-1:0] assigned,
  input wire aoa_pkg::aoa_mode_e mode,
  input wire logic fault_act,
  input wire logic [7:0] vote,
  input wire logic [CONC_W-1:0] avg_on,
  input wire logic [CONC_W-1:0] avg_off,
  aoa_dec_if.eval dec
);
  localparam int ACC_W = CONC_W + 8;
  if (NUM_IN < 1 || NUM_IN > 24) begin : g_chk
    $error("aoa_eval: NUM_IN must be 1..24");
  end

  function automatic logic [7:0] ones(input logic [NUM_IN-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < NUM_IN; i++) n = n + 8'(v[i]);
    return n;
  endfunction : ones

  logic [ACC_W-1:0] sum;
  logic [7:0] n_asg;
  logic [ACC_W-1:0] on_p;
  logic [ACC_W-1:0] off_p;
  logic normal;
  logic at_on;
  logic at_off;
  logic vote_ok;
  logic avg_hold;

  // Compare sum against threshold times count so no divider is needed
  always_comb begin
    sum = '0;
    for (int i = 0; i < NUM_IN; i++)
      if (assigned[i]) sum = sum + ACC_W'(conc[i*CONC_W +: CONC_W]);
  end
  assign n_asg = ones(assigned);
  assign on_p = ACC_W'(avg_on) * ACC_W'(n_asg);
  assign off_p = ACC_W'(avg_off) * ACC_W'(n_asg);
  assign normal = avg_on >= avg_off;
  assign at_on = normal ? (sum >= on_p) : (sum <= on_p);
  assign at_off = normal ? (sum <= off_p) : (sum >= off_p);
  assign vote_ok = (vote != 8'h00) && (ones(alarm & assigned) >= vote);
  assign dec.any_fault = |(fault & assigned);

  always_ff @(posedge clk) begin
    if (rst || !dec.en || mode != aoa_pkg::AOA_MODE_AVG || n_asg == 8'h00) begin
      avg_hold <= 1'b0;
    end else if (at_on) begin
      avg_hold <= 1'b1;
    end else if (at_off) begin
      avg_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !dec.en) begin
      dec.req <= 1'b0;
    end else begin
      dec.req <= ((mode == aoa_pkg::AOA_MODE_AVG) ? avg_hold : vote_ok)
        | (fault_act & dec.any_fault);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire avg_ok = dec.en && mode == aoa_pkg::AOA_MODE_AVG && n_asg != 8'h00;
  property p_avg_norm_on;
    avg_ok && normal && sum >= on_p |=> avg_hold;
  endproperty
  a_avg_norm_on: assert property (p_avg_norm_on) else $error("mean at on not held");
  property p_avg_inv_on;
    avg_ok && !normal && sum <= on_p |=> avg_hold;
  endproperty
  a_avg_inv_on: assert property (p_avg_inv_on) else $error("low mean not held");
  property p_avg_inv_off;
    avg_ok && !normal && sum > on_p && sum >= off_p |=> !avg_hold;
  endproperty
  a_avg_inv_off: assert property (p_avg_inv_off) else $error("high mean not released");
  property p_vote_mode;
    dec.en && mode == aoa_pkg::AOA_MODE_VOTE && !fault_act |=> dec.req == $past(vote_ok);
  endproperty
  a_vote_mode: assert property (p_vote_mode) else $error("voting request wrong");
  property p_fault;
    dec.en && fault_act && (fault & assigned) != '0 |=> dec.req;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not request");
  property p_dis;
    !dec.en |=> !dec.req;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled output requested");
endmodule : aoa_eval

// ===== hdl/aoa_delay.sv
// Make and break delay stage with latching, timed by a one-second tick
`timescale 1ns/100ps
`include "aoa_cfg.svh"
module aoa_delay #(
  parameter int TICK_CYCLES = `AOA_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  aoa_dec_if.dly dec
);
  if (TICK_CYCLES < 1) begin : g_chk
    $error("aoa_delay: TICK_CYCLES must be at least 1");
  end
  aoa_pkg::aoa_state_e state;
  logic [31:0] div;
  logic tick;
  aoa_pkg::aoa_dly_t cnt;

  // Divider restarts with each timing phase so a delay is exactly N ticks long
  always_ff @(posedge clk) begin
    if (rst || state == aoa_pkg::AOA_ST_OFF || state == aoa_pkg::AOA_ST_ON || tick) begin
      div <= 32'h0000_0000;
    end else begin
      div <= div + 32'h0000_0001;
    end
  end
  assign tick = div == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst || !dec.en) begin
      state <= aoa_pkg::AOA_ST_OFF;
      cnt <= 14'h0000;
    end else begin
      case (state)
        aoa_pkg::AOA_ST_OFF: begin
          cnt <= 14'h0000;
          if (dec.req) begin
            state <= (dec.make_dly == 14'h0000) ? aoa_pkg::AOA_ST_ON : aoa_pkg::AOA_ST_MAKE;
          end
        end
        aoa_pkg::AOA_ST_MAKE: begin
          if (!dec.req) begin
            state <= aoa_pkg::AOA_ST_OFF;
            cnt <= 14'h0000;
          end else if (tick) begin
            if (cnt + 14'h0001 >= dec.make_dly) state <= aoa_pkg::AOA_ST_ON;
            cnt <= cnt + 14'h0001;
          end
        end
        aoa_pkg::AOA_ST_ON: begin
          cnt <= 14'h0000;
          if (dec.latched) begin
            if (dec.clr) state <= aoa_pkg::AOA_ST_OFF;
          end else if (!dec.req) begin
            state <= (dec.brk_dly == 14'h0000) ? aoa_pkg::AOA_ST_OFF : aoa_pkg::AOA_ST_BRK;
          end
        end
        aoa_pkg::AOA_ST_BRK: begin
          if (dec.req || dec.latched) begin
            state <= aoa_pkg::AOA_ST_ON;
            cnt <= 14'h0000;
          end else if (tick) begin
            if (cnt + 14'h0001 >= dec.brk_dly) state <= aoa_pkg::AOA_ST_OFF;
            cnt <= cnt + 14'h0001;
          end
        end
        default: state <= aoa_pkg::AOA_ST_OFF;
      endcase
    end
  end
  assign dec.act = state == aoa_pkg::AOA_ST_ON || state == aoa_pkg::AOA_ST_BRK;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_make_done;
    dec.en && state == aoa_pkg::AOA_ST_MAKE && tick
      && cnt + 14'h0001 >= dec.make_dly && dec.req;
  endsequence
  property p_make;
    dec.en && $rose(dec.act) |-> $past(dec.req) && ($past(dec.make_dly) == 14'h0000
      || $past(state) == aoa_pkg::AOA_ST_MAKE);
  endproperty
  a_make: assert property (p_make) else $error("actuated without make delay");
  property p_make_end;
    s_make_done |=> dec.act;
  endproperty
  a_make_end: assert property (p_make_end) else $error("make delay overrun");
  property p_break;
    dec.en && $fell(dec.act) && !$past(dec.latched) |-> !$past(dec.req);
  endproperty
  a_break: assert property (p_break) else $error("released with alarm present");
  property p_latch;
    dec.en && dec.act && dec.latched && !dec.clr ##1 dec.en |-> dec.act;
  endproperty
  a_latch: assert property (p_latch) else $error("latched output released");
  property p_restart;
    dec.en && state == aoa_pkg::AOA_ST_MAKE && !dec.req |=> state == aoa_pkg::AOA_ST_OFF
      && cnt == 14'h0000 ##1 div == 32'h0000_0000;
  endproperty
  a_restart: assert property (p_restart) else $error("make count not restarted");
endmodule : aoa_delay

// ===== hdl/aoa_top.sv
// Alarm output actuation block with AXI4-Lite registers and interrupt
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "aoa_cfg.svh"
module aoa_top #(
  parameter int NUM_IN = 8,
  parameter int CONC_W = 16,
  parameter int TICK_CYCLES = `AOA_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_IN*CONC_W-1:0] conc_in,
  input wire logic [NUM_IN-1:0] input_alarm,
  input wire logic [NUM_IN-1:0] input_lost_fault,
  input wire logic latch_clear_request,
  output logic out_active,
  output logic relay_coil,
  output logic irq
);
  if (CONC_W < 1 || CONC_W > 16) begin : g_chk
    $error("aoa_top: CONC_W must be 1..16");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : merge

  function automatic aoa_pkg::aoa_dly_t clamp(input logic [31:0] v);
    return (v > 32'(`AOA_DLY_MAX)) ? `AOA_DLY_MAX : v[13:0];
  endfunction : clamp

  // Two-flop synchronisers for everything arriving from the remote modules
  logic [NUM_IN*CONC_W-1:0] conc_m, conc_s;
  logic [NUM_IN-1:0] alarm_m, alarm_s, fault_m, fault_s;
  logic clr_m, clr_s, clr_d;
  always_ff @(posedge clk) begin
    conc_m <= conc_in;
    conc_s <= conc_m;
    alarm_m <= input_alarm;
    alarm_s <= alarm_m;
    fault_m <= input_lost_fault;
    fault_s <= fault_m;
    clr_m <= latch_clear_request;
    clr_s <= clr_m;
  end
  always_ff @(posedge clk) begin
    if (rst) clr_d <= 1'b0;
    else clr_d <= clr_s;
  end

  // Registers
  logic [31:0] ctrl;
  logic [NUM_IN-1:0] assigned;
  logic [CONC_W-1:0] avg_on, avg_off;
  aoa_pkg::aoa_dly_t make_dly, brk_dly;
  logic [2:0] istat, imask;
  logic sw_clr;

  // AXI4-Lite write path: address and data taken in either order
  logic aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic wr_go, wr_ok;
  assign s_axi_awready = !aw_h && !s_axi_bvalid;
  assign s_axi_wready = !w_h && !s_axi_bvalid;
  assign wr_go = aw_h && w_h && !s_axi_bvalid;
  always_comb begin
    case (aw_a)
      `AOA_CTRL_OFS, `AOA_ASSIGN_OFS, `AOA_AVG_ON_OFS, `AOA_AVG_OFF_OFS, `AOA_MAKE_OFS,
      `AOA_BRK_OFS, `AOA_STAT_OFS, `AOA_ISTAT_OFS, `AOA_IMASK_OFS, `AOA_CMD_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h <= 1'b1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h <= 1'b1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `AOA_CTRL_RST;
      assigned <= NUM_IN'(`AOA_ASSIGN_RST);
      avg_on <= CONC_W'(`AOA_AVG_RST);
      avg_off <= CONC_W'(`AOA_AVG_RST);
      make_dly <= `AOA_DLY_DEF;
      brk_dly <= `AOA_DLY_DEF;
      imask <= 3'h0;
    end else if (wr_go) begin
      case (aw_a)
        `AOA_CTRL_OFS: ctrl <= merge(ctrl, w_d, w_s) & 32'h0000_ff3f;
        `AOA_ASSIGN_OFS: assigned <= NUM_IN'(merge(32'(assigned), w_d, w_s));
        `AOA_AVG_ON_OFS: avg_on <= CONC_W'(merge(32'(avg_on), w_d, w_s));
        `AOA_AVG_OFF_OFS: avg_off <= CONC_W'(merge(32'(avg_off), w_d, w_s));
        `AOA_MAKE_OFS: make_dly <= clamp(merge(32'(make_dly), w_d, w_s));
        `AOA_BRK_OFS: brk_dly <= clamp(merge(32'(brk_dly), w_d, w_s));
        `AOA_IMASK_OFS: imask <= 3'(merge(32'(imask), w_d, w_s));
        default: ;
      endcase
    end
  end

  // Software clear is a one-cycle pulse from a write of one to the command word
  always_ff @(posedge clk) begin
    if (rst) sw_clr <= 1'b0;
    else sw_clr <= wr_go && aw_a == `AOA_CMD_OFS && w_s[0] && w_d[0];
  end

  // Decision path; relay and sounder styles run the very same logic
  aoa_dec_if dec ();
  assign dec.en = ctrl[`AOA_CTRL_EN];
  assign dec.latched = ctrl[`AOA_CTRL_LATCH];
  assign dec.clr = sw_clr || (clr_s && !clr_d);
  assign dec.make_dly = make_dly;
  assign dec.brk_dly = brk_dly;

  aoa_eval #(.NUM_IN(NUM_IN), .CONC_W(CONC_W)) u_eval (
    .clk(clk),
    .rst(rst),
    .conc(conc_s),
    .alarm(alarm_s),
    .fault(fault_s),
    .assigned(assigned),
    .mode(aoa_pkg::aoa_mode_e'(ctrl[`AOA_CTRL_MODE])),
    .fault_act(ctrl[`AOA_CTRL_FAULT]),
    .vote(ctrl[`AOA_CTRL_VOTE_LSB +: 8]),
    .avg_on(avg_on),
    .avg_off(avg_off),
    .dec(dec.eval)
  );

  aoa_delay #(.TICK_CYCLES(TICK_CYCLES)) u_delay (
    .clk(clk),
    .rst(rst),
    .dec(dec.dly)
  );

  // Outputs and interrupt events
  logic flt_d;
  always_ff @(posedge clk) begin
    if (rst) begin
      out_active <= 1'b0;
      relay_coil <= 1'b0;
      flt_d <= 1'b0;
    end else begin
      out_active <= dec.act;
      relay_coil <= dec.act ^ ctrl[`AOA_CTRL_SENSE];
      flt_d <= dec.any_fault && dec.en;
    end
  end

  logic [2:0] ev, w1c;
  assign ev[`AOA_IRQ_ACT] = dec.act && !out_active;
  assign ev[`AOA_IRQ_REL] = !dec.act && out_active;
  assign ev[`AOA_IRQ_FLT] = dec.any_fault && dec.en && !flt_d;
  assign w1c = (wr_go && aw_a == `AOA_ISTAT_OFS && w_s[0]) ? w_d[2:0] : 3'h0;
  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) istat <= 3'h0;
    else istat <= (istat & ~w1c) | ev;
  end
  assign irq = |(istat & imask);

  // AXI4-Lite read path
  logic [31:0] rd;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `AOA_CTRL_OFS: rd = ctrl;
      `AOA_ASSIGN_OFS: rd = 32'(assigned);
      `AOA_AVG_ON_OFS: rd = 32'(avg_on);
      `AOA_AVG_OFF_OFS: rd = 32'(avg_off);
      `AOA_MAKE_OFS: rd = 32'(make_dly);
      `AOA_BRK_OFS: rd = 32'(brk_dly);
      `AOA_STAT_OFS: rd = {28'h0000000, dec.any_fault, relay_coil, dec.act, dec.req};
      `AOA_ISTAT_OFS: rd = 32'(istat);
      `AOA_IMASK_OFS: rd = 32'(imask);
      `AOA_CMD_OFS: rd = 32'h0000_0000;
      default: begin
        rd = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_coil;
    out_active |-> relay_coil != $past(ctrl[`AOA_CTRL_SENSE]);
  endproperty
  a_coil: assert property (p_coil) else $error("coil sense wrong while active");
  property p_dis_out;
    !dec.en [*3] |-> !out_active;
  endproperty
  a_dis_out: assert property (p_dis_out) else $error("disabled output active");
  property p_irq;
    $rose(dec.act) && imask[`AOA_IRQ_ACT] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("actuation interrupt missing");
  property p_istat_set;
    ev[`AOA_IRQ_ACT] |=> istat[`AOA_IRQ_ACT];
  endproperty
  a_istat_set: assert property (p_istat_set) else $error("actuation event lost");
endmodule : aoa_top

// ===== bench/aoa_sensor_model.sv
// Behavioural model of the remote sensors and analog inputs feeding the alarm output
`timescale 1ns/100ps
module aoa_sensor_model #(
  parameter logic [15:0] ALARM_LVL = 16'h0064
) (
  input wire logic clk,
  output logic [127:0] conc,
  output logic [7:0] alarm,
  output logic [7:0] fault
);
  initial begin
    conc = '0;
    fault = '0;
  end
  // Each input flags its own alarm from the one ALARM_LVL level shared by all inputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      alarm[i] = (conc[i*16+:16] >= ALARM_LVL);
    end
  end
  // Readings change only after a clock edge, like a polled remote module
  task set(input int idx, input logic [15:0] c, input logic f);
    @(posedge clk);
    conc[idx*16+:16] <= c;
    fault[idx] <= f;
  endtask : set
endmodule : aoa_sensor_model

// ===== bench/alarm_output_actuation_bench.sv
// Self-checking bench of the alarm output block
`timescale 1ns/100ps
module alarm_output_actuation_bench;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, clr_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, out_active, relay_coil, irq;
  logic [127:0] conc;
  logic [7:0] alarm, fault;
  int fails, n_checks;
  aoa_top #(.TICK_CYCLES(8)) aoa_top_inst (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conc_in(conc), .input_alarm(alarm), .input_lost_fault(fault),
    .latch_clear_request(clr_req), .out_active(out_active), .relay_coil(relay_coil),
    .irq(irq));
  aoa_sensor_model aoa_sensor_model_inst (.clk(clk), .conc(conc), .alarm(alarm),
    .fault(fault));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Ready and valid are sampled mid-cycle; they only move after rising edges
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic at, wt, bv;
    logic [1:0] r;
    bv = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!bv) begin
      @(negedge clk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bv = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
      if (bv) bready <= 0;
    end
    check(r, er);
  endtask : axi_write
  task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic at, rv;
    rv = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!rv) begin
      @(negedge clk);
      at = arvalid && arready;
      rv = (rvalid === 1'b1);
      if (rv) check(rdata, ed);
      if (rv) check(rresp, er);
      @(posedge clk);
      if (at) arvalid <= 0;
      if (rv) rready <= 0;
    end
  endtask : axi_read
  task wait_out(input logic e, input int lim);
    int k;
    k = 0;
    while (out_active !== e && k < lim) begin
      @(negedge clk);
      k++;
    end
    check(out_active, e);
  endtask : wait_out
  task hold_out(input logic e, input int n);
    repeat (n) begin
      @(negedge clk);
      check(out_active, e);
    end
  endtask : hold_out
  task cfg(input logic [31:0] ctrl, input logic [31:0] asg, input int mk, input int bk);
    axi_write(8'h04, asg, 2'b00);
    axi_write(8'h10, mk, 2'b00);
    axi_write(8'h14, bk, 2'b00);
    axi_write(8'h00, ctrl, 2'b00);
  endtask : cfg
  task set2(input logic [15:0] c0, input logic [15:0] c1);
    aoa_sensor_model_inst.set(0, c0, 0);
    aoa_sensor_model_inst.set(1, c1, 0);
  endtask : set2
  task t_regs;
    axi_read(8'h00, 32'h0000_0100, 2'b00);
    axi_read(8'h04, 32'h0000_0000, 2'b00);
    axi_read(8'h10, 32'h0000_000a, 2'b00);
    axi_read(8'h14, 32'h0000_000a, 2'b00);
    axi_read(8'h28, 32'h0000_0000, 2'b10);
    axi_write(8'h28, 32'h0000_0001, 2'b10);
    axi_write(8'h10, 32'h0000_3fff, 2'b00);
    axi_read(8'h10, 32'h0000_270f, 2'b00);
  endtask : t_regs
  task t_vote;
    axi_write(8'h08, 32'h0, 2'b00);
    axi_write(8'h0c, 32'h0, 2'b00);
    cfg(32'h0000_0211, 32'h0000_0003, 0, 0);
    aoa_sensor_model_inst.set(0, 16'h00c8, 0);
    aoa_sensor_model_inst.set(2, 16'h00c8, 0);
    hold_out(1'b0, 12);
    check(relay_coil, 1'b1);
    aoa_sensor_model_inst.set(1, 16'h00c8, 0);
    wait_out(1'b1, 20);
    @(negedge clk);
    check(relay_coil, 1'b0);
    axi_read(8'h18, 32'h0000_0003, 2'b00);
    check(irq, 1'b0);
    axi_write(8'h20, 32'h0000_0003, 2'b00);
    check(irq, 1'b1);
    set2(0, 0);
    aoa_sensor_model_inst.set(2, 0, 0);
    wait_out(1'b0, 20);
    axi_read(8'h1c, 32'h0000_0003, 2'b00);
    axi_write(8'h1c, 32'h0000_0007, 2'b00);
    @(negedge clk);
    check(irq, 1'b0);
    axi_write(8'h20, 32'h0, 2'b00);
  endtask : t_vote
  // Two ticks of eight cycles each before make and before break
  task t_delay;
    cfg(32'h0000_0101, 32'h0000_0001, 2, 2);
    aoa_sensor_model_inst.set(0, 16'h00c8, 0);
    hold_out(1'b0, 10);
    aoa_sensor_model_inst.set(0, 0, 0);
    hold_out(1'b0, 4);
    aoa_sensor_model_inst.set(0, 16'h00c8, 0);
    hold_out(1'b0, 14);
    wait_out(1'b1, 20);
    aoa_sensor_model_inst.set(0, 0, 0);
    hold_out(1'b1, 14);
    wait_out(1'b0, 20);
  endtask : t_delay
  // Unassigned zeros would pull an all-input mean below the on level
  task t_avg;
    axi_write(8'h08, 32'h0000_0064, 2'b00);
    axi_write(8'h0c, 32'h0000_0032, 2'b00);
    cfg(32'h0000_0123, 32'h0000_0003, 0, 0);
    set2(16'h0096, 16'h0031);
    hold_out(1'b0, 10);
    set2(16'h0096, 16'h0032);
    wait_out(1'b1, 20);
    set2(16'h003c, 16'h0032);
    hold_out(1'b1, 10);
    set2(16'h003c, 16'h0028);
    wait_out(1'b0, 20);
  endtask : t_avg
  task t_inv;
    set2(16'h003c, 16'h003c);
    axi_write(8'h08, 32'h0000_001e, 2'b00);
    axi_write(8'h0c, 32'h0000_0050, 2'b00);
    cfg(32'h0000_0103, 32'h0000_0003, 0, 0);
    hold_out(1'b0, 10);
    set2(16'h0028, 16'h0014);
    wait_out(1'b1, 20);
    set2(16'h003c, 16'h003c);
    hold_out(1'b1, 10);
    set2(16'h0050, 16'h0050);
    wait_out(1'b0, 20);
    // Zero inputs would actuate this inverted setting, so disable first
    axi_write(8'h00, 32'h0000_0000, 2'b00);
    wait_out(1'b0, 4);
    set2(0, 0);
  endtask : t_inv
  task t_fault_latch;
    cfg(32'h0000_000d, 32'h0000_0001, 0, 0);
    aoa_sensor_model_inst.set(1, 0, 1);
    hold_out(1'b0, 10);
    aoa_sensor_model_inst.set(0, 0, 1);
    wait_out(1'b1, 20);
    aoa_sensor_model_inst.set(0, 0, 0);
    aoa_sensor_model_inst.set(1, 0, 0);
    hold_out(1'b1, 12);
    @(posedge clk);
    clr_req <= 1;
    repeat (4) @(posedge clk);
    clr_req <= 0;
    wait_out(1'b0, 20);
    aoa_sensor_model_inst.set(0, 0, 1);
    wait_out(1'b1, 20);
    aoa_sensor_model_inst.set(0, 0, 0);
    hold_out(1'b1, 8);
    axi_write(8'h24, 32'h0000_0001, 2'b00);
    wait_out(1'b0, 20);
  endtask : t_fault_latch
  task t_disable;
    cfg(32'h0000_0106, 32'h0000_0001, 0, 0);
    aoa_sensor_model_inst.set(0, 16'h00c8, 1);
    hold_out(1'b0, 12);
    check(relay_coil, 1'b0);
    aoa_sensor_model_inst.set(0, 0, 0);
  endtask : t_disable
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
  initial begin
    fails = 0; n_checks = 0; rst = 1; clr_req = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = '0; araddr = '0; wdata = '0;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    check(out_active, 1'b0);
    check(irq, 1'b0);
    t_regs;
    t_vote;
    t_delay;
    t_avg;
    t_inv;
    t_fault_latch;
    t_disable;
    test_done;
  end
endmodule : alarm_output_actuation_bench
